// >>> hdl/ccr_comparator_control.sv
// Comparator control and status register bank with an APB slave and an interrupt output.
// Assumes the analog comparator outside reports its raw decision synchronously to clock.
//
// Our own choice: the APB register port.
`timescale 1ns/1ns

module ccr_comparator_control
    import ccr_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        comparator_raw,
    output logic             comparator_power,
    output logic             positive_input_connect,
    output logic      [1:0]  negative_input_select,
    output logic             negative_input_connect,
    output logic             response_fast,
    output logic             hysteresis_on,
    output logic             output_pin,
    output logic             comparator_irq_request,
    output logic             irq
);

    // ==========================================================================
    // Decoding helpers
    // ==========================================================================
    function automatic logic [1:0] field2(input logic [15:0] word, input int lsb);
        field2 = word[lsb +: 2];
    endfunction

    function automatic logic [8:0] settle_load(input logic [1:0] speed);
        settle_load = (speed == CCR_SPEED_FAST) ? CCR_FAST_CYCLES : CCR_SLOW_CYCLES;
    endfunction

    // ==========================================================================
    // State
    // ==========================================================================
    logic [15:0]              ctrl_cfg;
    logic                     rise_flag;
    logic                     fall_flag;
    logic [CCR_EVT_WIDTH-1:0] irq_status;
    logic [CCR_EVT_WIDTH-1:0] irq_mask;
    logic [8:0]               settle_count;
    logic                     armed;
    logic                     level_prev;

    // ==========================================================================
    // APB decode
    // ==========================================================================
    wire        apb_setup  = psel & ~penable;
    wire        apb_commit = psel & penable & pready;
    wire        hit_ctrl   = (paddr == CCR_ADDR_CONTROL);
    wire        hit_level  = (paddr == CCR_ADDR_LEVEL);
    wire        hit_status = (paddr == CCR_ADDR_IRQ_STATUS);
    wire        hit_mask   = (paddr == CCR_ADDR_IRQ_MASK);
    wire        hit_any    = hit_ctrl | hit_level | hit_status | hit_mask;
    wire        wr_ctrl    = apb_commit & pwrite & hit_ctrl;
    wire        wr_mask    = apb_commit & pwrite & hit_mask;
    wire        rd_status  = apb_commit & ~pwrite & hit_status;
    wire [15:0] wdata16    = pwdata[15:0];
    wire [1:0]  wr_neg     = field2(wdata16, CCR_NEG_LSB);
    wire [1:0]  wr_speed   = field2(wdata16, CCR_SPEED_LSB);

    // ==========================================================================
    // Configuration fields
    // ==========================================================================
    wire       cfg_enable = ctrl_cfg[CCR_BIT_ENABLE];
    wire [1:0] cfg_neg    = field2(ctrl_cfg, CCR_NEG_LSB);
    wire [1:0] cfg_route  = field2(ctrl_cfg, CCR_ROUTE_LSB);
    wire       cfg_pol    = ctrl_cfg[CCR_BIT_POL];
    wire [1:0] cfg_speed  = field2(ctrl_cfg, CCR_SPEED_LSB);

    // Flags are kept apart so that a configuration write only clears them where it writes a one.
    wire [15:0] next_ctrl_cfg = wr_ctrl ? (wdata16 & CCR_CFG_MASK) : ctrl_cfg;
    wire [15:0] ctrl_view     = ctrl_cfg | {14'h0000, rise_flag, fall_flag};

    // ==========================================================================
    // Comparator monitoring
    // ==========================================================================
    // The raw decision is high while the positive input is above the negative one.
    wire monitored = comparator_raw ^ cfg_pol;
    wire settled   = cfg_enable & (settle_count == '0);
    // Any reconfiguration restarts the settling wait, so a change of input or polarity
    // never shows up as a false edge. The cost is a blind window of one response time.
    wire [8:0] next_settle_count =
        (wr_ctrl | ~cfg_enable) ? settle_load(field2(next_ctrl_cfg, CCR_SPEED_LSB)) :
        (settle_count != '0)    ? settle_count - 9'h001 : settle_count;
    wire next_armed  = settled & ~wr_ctrl;
    wire rise_event  = armed & settled & monitored & ~level_prev;
    wire fall_event  = armed & settled & ~monitored & level_prev;

    // A flag set and its write-one clear in the same cycle leave the flag set.
    wire clr_rise       = wr_ctrl & wdata16[CCR_BIT_RISE];
    wire clr_fall       = wr_ctrl & wdata16[CCR_BIT_FALL];
    wire next_rise_flag = rise_event | (rise_flag & ~clr_rise);
    wire next_fall_flag = fall_event | (fall_flag & ~clr_fall);

    // ==========================================================================
    // Interrupt status
    // ==========================================================================
    // Only the bits that the read actually returned are cleared, so an event arriving
    // between the setup and access phases survives.
    wire [1:0] evt_vec         = {rise_event, fall_event};
    wire [1:0] status_clear    = rd_status ? prdata[1:0] : 2'h0;
    wire [1:0] next_irq_status = evt_vec | (irq_status & ~status_clear);
    wire [1:0] next_irq_mask   = wr_mask ? wdata16[1:0] : irq_mask;

    // ==========================================================================
    // Next output values
    // ==========================================================================
    wire       nx_enable    = next_ctrl_cfg[CCR_BIT_ENABLE];
    wire [1:0] nx_route     = field2(next_ctrl_cfg, CCR_ROUTE_LSB);
    wire [1:0] nx_neg       = field2(next_ctrl_cfg, CCR_NEG_LSB);
    wire       nx_fast      = field2(next_ctrl_cfg, CCR_SPEED_LSB) == CCR_SPEED_FAST;
    wire       next_pin     = nx_enable & (nx_route == CCR_ROUTE_PIN) & monitored;
    wire       next_cmp_irq = (nx_route == CCR_ROUTE_IRQ) &
                              (next_rise_flag | next_fall_flag);
    wire       next_irq     = |(next_irq_status & next_irq_mask);

    // ==========================================================================
    // APB read path
    // ==========================================================================
    wire [31:0] read_value =
        hit_ctrl   ? {16'h0000, ctrl_view} :
        hit_level  ? {30'h0000_0000, settled, monitored} :
        hit_status ? {30'h0000_0000, irq_status} :
        hit_mask   ? {30'h0000_0000, irq_mask} : 32'h0000_0000;
    wire [31:0] next_prdata  = (apb_setup & ~pwrite) ? read_value : 32'h0000_0000;
    wire        next_pslverr = apb_setup & ~hit_any;

    // ==========================================================================
    // Registers
    // ==========================================================================
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_cfg   <= CCR_CTRL_RESET;
            rise_flag  <= 1'b0;
            fall_flag  <= 1'b0;
            irq_status <= 2'h0;
            irq_mask   <= 2'h0;
        end else begin
            ctrl_cfg   <= next_ctrl_cfg;
            rise_flag  <= next_rise_flag;
            fall_flag  <= next_fall_flag;
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            settle_count <= CCR_SLOW_CYCLES;
            armed        <= 1'b0;
            level_prev   <= 1'b0;
        end else begin
            settle_count <= next_settle_count;
            armed        <= next_armed;
            level_prev   <= monitored;
        end
    end

    // Register reads answer with one wait-free access phase after every setup.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= apb_setup;
            pslverr <= next_pslverr;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            comparator_power       <= 1'b0;
            positive_input_connect <= 1'b0;
            negative_input_select  <= CCR_NEG_HALF_SUPPLY;
            negative_input_connect <= 1'b0;
            response_fast          <= 1'b0;
            hysteresis_on          <= 1'b0;
            output_pin             <= 1'b0;
            comparator_irq_request <= 1'b0;
            irq                    <= 1'b0;
        end else begin
            comparator_power       <= nx_enable;
            positive_input_connect <= nx_enable;
            negative_input_select  <= nx_neg;
            negative_input_connect <= nx_enable & (nx_neg != CCR_NEG_RESERVED);
            response_fast          <= nx_fast;
            hysteresis_on          <= next_ctrl_cfg[CCR_BIT_HYST];
            output_pin             <= next_pin;
            comparator_irq_request <= next_cmp_irq;
            irq                    <= next_irq;
        end
    end

    // ==========================================================================
    // Assertions
    // ==========================================================================
    default clocking ccr_cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_enable_follows;
        wr_ctrl |=> (comparator_power == $past(pwdata[CCR_BIT_ENABLE]))
                    && (positive_input_connect == comparator_power);
    endproperty
    a_enable_follows: assert property (p_enable_follows)
        else $error("Comparator power does not follow the enable bit.");

    property p_neg_select;
        wr_ctrl |=> (negative_input_select == $past(wr_neg))
                    && (negative_input_connect ==
                        ($past(pwdata[CCR_BIT_ENABLE]) && $past(wr_neg) != CCR_NEG_RESERVED));
    endproperty
    a_neg_select: assert property (p_neg_select)
        else $error("Negative input select output is wrong after a write.");

    property p_pin_route;
        output_pin |-> (cfg_route == CCR_ROUTE_PIN) && cfg_enable;
    endproperty
    a_pin_route: assert property (p_pin_route)
        else $error("Output pin driven while not routed to the pin.");

    property p_reserved_route;
        (cfg_route != CCR_ROUTE_PIN) && (cfg_route != CCR_ROUTE_IRQ)
            |-> !output_pin && !comparator_irq_request;
    endproperty
    a_reserved_route: assert property (p_reserved_route)
        else $error("Reserved route code drives an output.");

    property p_polarity;
        (cfg_route == CCR_ROUTE_PIN) && cfg_enable && !wr_ctrl
            |=> output_pin == ($past(comparator_raw) ^ $past(cfg_pol));
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("Output pin does not match raw result under polarity.");

    property p_settle_load;
        wr_ctrl |=> settle_count ==
            (($past(wr_speed) == CCR_SPEED_FAST) ? CCR_FAST_CYCLES : CCR_SLOW_CYCLES);
    endproperty
    a_settle_load: assert property (p_settle_load)
        else $error("Settling wait not loaded from the response speed.");

    property p_hysteresis;
        wr_ctrl |=> hysteresis_on == $past(pwdata[CCR_BIT_HYST])
                    && response_fast == ($past(wr_speed) == CCR_SPEED_FAST);
    endproperty
    a_hysteresis: assert property (p_hysteresis)
        else $error("Hysteresis or speed output does not follow the write.");

    property p_rise_sticky;
        ($rose(monitored) && settled && $past(settled) && !$past(wr_ctrl))
            || (rise_flag && !clr_rise) |=> rise_flag;
    endproperty
    a_rise_sticky: assert property (p_rise_sticky)
        else $error("Rise flag lost without a write-one clear.");

    property p_fall_sticky;
        $fell(monitored) && settled && $past(settled) && !$past(wr_ctrl) |=> fall_flag;
    endproperty
    a_fall_sticky: assert property (p_fall_sticky)
        else $error("Falling edge did not set the fall flag.");

    property p_zero_write_keeps;
        wr_ctrl && rise_flag && !wdata16[CCR_BIT_RISE] |=> rise_flag;
    endproperty
    a_zero_write_keeps: assert property (p_zero_write_keeps)
        else $error("Writing zero cleared the rise flag.");

    property p_ctrl_read;
        apb_setup && !pwrite && hit_ctrl
            |=> pready && prdata[31:11] == '0
                && prdata[1:0] == {$past(rise_flag), $past(fall_flag)};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("Control read returns a wrong or unclean word.");

    // A write of one clears a flag only when no new edge lands in that same cycle.
    property p_flag_clear;
        wr_ctrl && !rise_event && !fall_event
            |=> (!rise_flag || !$past(wdata16[CCR_BIT_RISE]))
                && (!fall_flag || !$past(wdata16[CCR_BIT_FALL]));
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("A write of one did not clear its event flag.");

    property p_ctrl_write;
        wr_ctrl |=> ctrl_cfg == ($past(wdata16) & CCR_CFG_MASK);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("Control write did not land or kept reserved bits.");

    property p_power_off;
        !comparator_power
            |-> !output_pin && !positive_input_connect && !negative_input_connect;
    endproperty
    a_power_off: assert property (p_power_off)
        else $error("Comparator paths stay live while powered off.");

    property p_bad_addr;
        apb_setup && !hit_any |=> pready && pslverr && (prdata == '0);
    endproperty
    a_bad_addr: assert property (p_bad_addr)
        else $error("Unmapped access not answered with an error.");

    property p_irq_level;
        irq == |(irq_status & irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("Interrupt output does not match unmasked status.");

    // Bits that the read returned must be gone, unless an edge set them again.
    property p_status_clear;
        rd_status && !rise_event && !fall_event
            |=> (irq_status & $past(prdata[1:0])) == 2'h0;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("Status read did not clear the returned bits.");

    c_rise_seen:  cover property (rise_event ##1 rise_flag);
    c_fall_seen:  cover property (fall_event ##1 fall_flag);
    c_irq_raised: cover property ($rose(irq));
    c_bad_addr:   cover property (pready && pslverr);

endmodule

// >>> hdl/ccr_pkg.sv
// Constants for the comparator control register bank: addresses, fields, codes, timing.
// Assumes a 25 MHz system clock and a 32-bit APB bus carrying full byte addresses.
package ccr_pkg;

    // ==========================================================================
    // Register addresses
    // ==========================================================================
    localparam logic [31:0] CCR_ADDR_CONTROL    = 32'hFFFF_0444;
    localparam logic [31:0] CCR_ADDR_LEVEL      = 32'hFFFF_0448;
    localparam logic [31:0] CCR_ADDR_IRQ_STATUS = 32'hFFFF_044C;
    localparam logic [31:0] CCR_ADDR_IRQ_MASK   = 32'hFFFF_0450;

    // ==========================================================================
    // Control register layout
    // ==========================================================================
    localparam int          CCR_CTRL_WIDTH = 16;
    localparam int          CCR_BIT_ENABLE = 10;
    localparam int          CCR_NEG_LSB    = 8;
    localparam int          CCR_ROUTE_LSB  = 6;
    localparam int          CCR_BIT_POL    = 5;
    localparam int          CCR_SPEED_LSB  = 3;
    localparam int          CCR_BIT_HYST   = 2;
    localparam int          CCR_BIT_RISE   = 1;
    localparam int          CCR_BIT_FALL   = 0;
    localparam logic [15:0] CCR_CTRL_RESET = 16'h0000;
    localparam logic [15:0] CCR_CFG_MASK   = 16'h07FC;
    localparam int          CCR_EVT_WIDTH  = 2;

    // ==========================================================================
    // Field codes
    // ==========================================================================
    localparam logic [1:0] CCR_NEG_HALF_SUPPLY = 2'h0;
    localparam logic [1:0] CCR_NEG_ANALOG_CH3  = 2'h1;
    localparam logic [1:0] CCR_NEG_DAC_CH0     = 2'h2;
    localparam logic [1:0] CCR_NEG_RESERVED    = 2'h3;
    localparam logic [1:0] CCR_ROUTE_PIN       = 2'h2;
    localparam logic [1:0] CCR_ROUTE_IRQ       = 2'h3;
    localparam logic [1:0] CCR_SPEED_SLOW      = 2'h0;
    localparam logic [1:0] CCR_SPEED_FAST      = 2'h3;

    // ==========================================================================
    // Timing
    // ==========================================================================
    localparam int CCR_CLOCK_NS        = 40;
    localparam int CCR_SLOW_RESPONSE_NS = 17000;
    localparam int CCR_FAST_RESPONSE_NS = 4000;
    localparam int CCR_SETTLE_WIDTH    = 9;
    localparam logic [8:0] CCR_SLOW_CYCLES =
        9'((CCR_SLOW_RESPONSE_NS + CCR_CLOCK_NS - 1) / CCR_CLOCK_NS);
    localparam logic [8:0] CCR_FAST_CYCLES =
        9'((CCR_FAST_RESPONSE_NS + CCR_CLOCK_NS - 1) / CCR_CLOCK_NS);

endpackage

// >>> tb/ccr_analog_model.sv
// Behavioural analog comparator at the far side of the control bank.
// Assumes the bench sets the input difference; LAT clocks of delay mimic response time.
`timescale 1ns/1ns

module ccr_analog_model #(
    parameter int LAT = 2
) (
    input  wire logic clock,
    input  wire logic power,
    input  wire logic pos_connect,
    input  wire logic neg_connect,
    input  wire logic above,
    output logic      comparator_raw
);
    logic [7:0] pipe = 8'h00;
    // An unpowered or unconnected comparator reports low, not its last decision.
    wire logic live = power & pos_connect & neg_connect & above;
    always_ff @(posedge clock) begin
        pipe <= {pipe[6:0], live};
    end
    assign comparator_raw = power & pipe[LAT-1];
endmodule

// >>> tb/ccr_comparator_control_tb_top.sv
// Self-checking bench for the comparator control bank, driven over APB.
// Assumes the bank answers one cycle after setup and the analog model sits on its far side.
`timescale 1ns/1ns

module ccr_comparator_control_tb_top;
    import ccr_pkg::*;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, raw, above;
    logic        power, pos_c, neg_c, fast, hyst, out_pin, creq, irq;
    logic [1:0]  nsel;
    logic [31:0] paddr, pwdata, prdata, r;
    logic        e;
    int          err_total, checks;

    ccr_comparator_control i_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .comparator_raw(raw),
        .comparator_power(power), .positive_input_connect(pos_c),
        .negative_input_select(nsel), .negative_input_connect(neg_c),
        .response_fast(fast), .hysteresis_on(hyst), .output_pin(out_pin),
        .comparator_irq_request(creq), .irq(irq));
    ccr_analog_model i_model (.clock(clock), .power(power), .pos_connect(pos_c),
        .neg_connect(neg_c), .above(above), .comparator_raw(raw));

    // ==========================================================================
    // Bus and report tasks
    // ==========================================================================
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One idle edge first, so a release never meets the next setup in one time step.
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin
            err_total++;
            stop_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("write error", {31'h0, e}, 32'h0);
    endtask

    task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, r, exp);
    endtask

    task automatic wait_settled();
        int n;
        for (n = 0; n < 300; n++) begin
            apb(1'b0, CCR_ADDR_LEVEL, 32'h0);
            if (r[1] === 1'b1) break;
        end
        if (n == 300) begin
            err_total++;
            stop_test();
        end
    endtask

    task automatic set_above(input logic v);
        @(posedge clock);
        above <= v;
        repeat (8) @(posedge clock);
        #1;
    endtask

    // ==========================================================================
    // Scenarios
    // ==========================================================================
    task automatic t_fields();
        rd("ctrl reset", CCR_ADDR_CONTROL, 32'h0000_0000);
        chk("power reset", {31'h0, power}, 32'h0);
        wr(CCR_ADDR_CONTROL, 32'hFFFF_FFFF);
        rd("ctrl reserved", CCR_ADDR_CONTROL, 32'h0000_07FC);
        chk("fast", {31'h0, fast}, 32'h1);
        chk("hyst on", {31'h0, hyst}, 32'h1);
        chk("neg conn rsvd", {31'h0, neg_c}, 32'h0);
        for (int s = 0; s < 3; s++) begin
            wr(CCR_ADDR_CONTROL, 32'h0000_0408 | (s << 8));
            chk("neg sel", {30'h0, nsel}, s);
            chk("neg conn", {31'h0, neg_c}, 32'h1);
            chk("pos conn", {31'h0, pos_c}, 32'h1);
            chk("slow", {31'h0, fast}, 32'h0);
            chk("hyst off", {31'h0, hyst}, 32'h0);
        end
        wr(CCR_ADDR_CONTROL, 32'h0000_0000);
        chk("power off", {31'h0, power}, 32'h0);
    endtask

    task automatic t_edges();
        wr(CCR_ADDR_IRQ_MASK, 32'h0000_0000);
        wr(CCR_ADDR_CONTROL, 32'h0000_0498);
        wait_settled();
        set_above(1'b1);
        chk("pin high", {31'h0, out_pin}, 32'h1);
        rd("level", CCR_ADDR_LEVEL, 32'h0000_0003);
        rd("rise flag", CCR_ADDR_CONTROL, 32'h0000_049A);
        chk("irq masked", {31'h0, irq}, 32'h0);
        set_above(1'b0);
        chk("pin low", {31'h0, out_pin}, 32'h0);
        rd("fall flag", CCR_ADDR_CONTROL, 32'h0000_049B);
        wr(CCR_ADDR_CONTROL, 32'h0000_0498);
        rd("zero write", CCR_ADDR_CONTROL, 32'h0000_049B);
        wr(CCR_ADDR_CONTROL, 32'h0000_049A);
        rd("rise clear", CCR_ADDR_CONTROL, 32'h0000_0499);
        wr(CCR_ADDR_IRQ_MASK, 32'h0000_0003);
        @(posedge clock);
        #1;
        chk("irq up", {31'h0, irq}, 32'h1);
        rd("status", CCR_ADDR_IRQ_STATUS, 32'h0000_0003);
        rd("status clr", CCR_ADDR_IRQ_STATUS, 32'h0000_0000);
        chk("irq down", {31'h0, irq}, 32'h0);
        wr(CCR_ADDR_CONTROL, 32'h0000_04BB);
        set_above(1'b0);
        chk("pin invert", {31'h0, out_pin}, 32'h1);
        rd("level inv", CCR_ADDR_LEVEL, 32'h0000_0001);
    endtask

    task automatic t_route();
        wr(CCR_ADDR_CONTROL, 32'h0000_0458);
        wait_settled();
        set_above(1'b1);
        chk("pin rsvd", {31'h0, out_pin}, 32'h0);
        chk("req rsvd", {31'h0, creq}, 32'h0);
        wr(CCR_ADDR_CONTROL, 32'h0000_04D8);
        @(posedge clock);
        #1;
        chk("req irq", {31'h0, creq}, 32'h1);
        chk("pin irq", {31'h0, out_pin}, 32'h0);
        apb(1'b1, 32'hFFFF_0454, 32'h0000_FFFF);
        chk("bad wr err", {31'h0, e}, 32'h1);
        apb(1'b0, 32'hFFFF_0454, 32'h0);
        chk("bad rd", {e, r[30:0]}, 32'h8000_0000);
        rd("ctrl kept", CCR_ADDR_CONTROL, 32'h0000_04DA);
    endtask

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        {rst_n, psel, penable, pwrite, above} = 5'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        err_total = 0;
        checks = 0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        t_fields();
        t_edges();
        t_route();
        stop_test();
    end
endmodule
